// ---- bench/dob_bridge_monitor.sv ----
`timescale 1ns/100ps
module dob_bridge_monitor
   import dob_pkg::*;
#(
   parameter logic [9:0] WINDOW_BASE = DOB_BASE_DEF,
   parameter logic [9:0] WINDOW_MASK = DOB_MASK_DEF,
   parameter logic [31:0] ADDR_OFFSET = DOB_OFFSET_DEF
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic [9:0] i_dcr_addr,
   input wire logic i_dcr_rd,
   input wire logic i_dcr_wr,
   input wire logic [31:0] i_dcr_data,
   input wire logic o_dcr_ack,
   input wire logic [31:0] o_dcr_data,
   input wire logic [31:0] o_opb_addr,
   input wire logic [3:0] o_opb_be,
   input wire logic [31:0] o_opb_wdata,
   input wire logic o_opb_rnw,
   input wire logic o_opb_select,
   input wire logic o_opb_seq,
   input wire logic i_opb_xfer_ack,
   input wire logic i_opb_retry,
   input wire logic i_opb_err_ack
);
   logic hit;
   logic strb;
   logic sack;
   assign hit = ((i_dcr_addr ^ WINDOW_BASE) & WINDOW_MASK) == 10'h000;
   assign strb = i_dcr_rd | i_dcr_wr;
   assign sack = i_opb_xfer_ack | i_opb_retry | i_opb_err_ack;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   a_be_all_ones: assert property (o_opb_be == DOB_BE_ALL)
      else $error("byte enables not all ones");
   a_seq_low: assert property (o_opb_seq == DOB_SEQ_OFF)
      else $error("sequential address raised");
   a_launch_hit: assert property ($rose(strb) && hit |->
      ##2 o_opb_select) else $error("hit did not launch");
   a_miss_idle: assert property ($rose(strb) && !hit |=> !o_opb_select[*4])
      else $error("miss launched a transfer");
   a_sel_to_ack: assert property (o_opb_select && sack |=>
      !o_opb_select ##1 o_dcr_ack) else $error("ack sequence wrong");
   a_ack_pulse: assert property (o_dcr_ack |=> !o_dcr_ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(o_dcr_ack) |-> $past(o_opb_select, 2))
      else $error("ack without slave transfer");
   a_addr_map: assert property ($rose(o_opb_select) |-> o_opb_addr ==
      {20'h0_0000, $past(i_dcr_addr), 2'h0} + ADDR_OFFSET)
      else $error("opb address wrong");
   a_rnw_dir: assert property ($rose(o_opb_select) |->
      o_opb_rnw == $past(i_dcr_rd)) else $error("direction wrong");
   a_wdata_reg: assert property ($rose(o_opb_select) && !o_opb_rnw |->
      o_opb_wdata == $past(i_dcr_data)) else $error("write data wrong");
   a_bypass_pipe: assert property ($past(i_nrst, 2) &&
      $past(i_nrst) && $past(i_ce) && $past(i_ce, 2) && !o_dcr_ack |->
      o_dcr_data == $past(i_dcr_data, 2)) else $error("bypass data wrong");
   c_retry_end: cover property (o_opb_select && i_opb_retry);
   c_err_end: cover property (o_opb_select && i_opb_err_ack);
   c_fast_read: cover property (o_opb_select && o_opb_rnw ##2 o_dcr_ack);
endmodule
bind dob_bridge dob_bridge_monitor #(.WINDOW_BASE(WINDOW_BASE),
   .WINDOW_MASK(WINDOW_MASK), .ADDR_OFFSET(ADDR_OFFSET)) mon_u (.*);

// ---- bench/dob_opb_slave.sv ----
`timescale 1ns/100ps
module dob_opb_slave (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_rnw,
   input wire logic i_select,
   input wire logic [3:0] i_wait,
   input wire logic [1:0] i_kind,
   output logic [31:0] o_rdata,
   output logic o_xfer_ack,
   output logic o_retry,
   output logic o_err_ack
);
   logic [31:0] mem_q [8];
   logic [3:0] cnt_q;
   logic [31:0] junk_q;
   logic ack;
   // ---
   // latency set by i_wait per access, no timeout suppress
   // ---
   assign ack = i_select && (cnt_q == i_wait);
   assign o_xfer_ack = ack && (i_kind == 2'h0);
   assign o_retry = ack && (i_kind == 2'h1);
   assign o_err_ack = ack && (i_kind == 2'h2);
   // idle bus keeps moving so a stale word never passes
   assign o_rdata = (ack && i_rnw) ? mem_q[i_addr[4:2]] : junk_q;
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 4'h0;
         junk_q <= 32'h5a5a_0f0f;
      end else begin
         cnt_q <= (i_select && !ack) ? cnt_q + 4'h1 : 4'h0;
         junk_q <= {junk_q[30:0], ~junk_q[31]};
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (ack && !i_rnw) mem_q[i_addr[4:2]] <= i_wdata;
   end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
   import dob_pkg::*;
   localparam logic [9:0] BASE = 10'h040;
   localparam logic [31:0] OFS = 32'h1000_0000;
   logic clk, nrst, ce, rd, wr, ack, sel, rnw, seq, xa, ry, ea;
   logic [9:0] addr;
   logic [31:0] din, dout, oa, wd, rdat;
   logic [3:0] be, wt;
   logic [1:0] kind;
   logic [31:0] exp_q[$];
   logic [31:0] shadow [8];
   int err_count, cmp_count, cyc, nacc;
   dob_bridge #(.WINDOW_BASE(BASE), .WINDOW_MASK(DOB_MASK_DEF),
      .ADDR_OFFSET(OFS)) dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce),
      .i_dcr_addr(addr), .i_dcr_rd(rd), .i_dcr_wr(wr), .i_dcr_data(din),
      .o_dcr_ack(ack), .o_dcr_data(dout), .o_opb_addr(oa), .o_opb_be(be),
      .o_opb_wdata(wd), .o_opb_rnw(rnw), .o_opb_select(sel),
      .o_opb_seq(seq), .i_opb_rdata(rdat), .i_opb_err_ack(ea),
      .i_opb_retry(ry), .i_opb_xfer_ack(xa));
   dob_opb_slave slv_u (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(oa),
      .i_wdata(wd), .i_rnw(rnw), .i_select(sel), .i_wait(wt), .i_kind(kind),
      .o_rdata(rdat), .o_xfer_ack(xa), .o_retry(ry), .o_err_ack(ea));
   task automatic close_out();
      if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      cmp_count++;
      if (got !== want) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   // one access; strobe held until ack, misses wait out a fixed span
   task automatic acc(input logic r, input logic [9:0] a,
                      input logic [31:0] d, input logic hit);
      int n;
      @(posedge clk);
      #1;
      addr = a;
      din = d;
      rd = r;
      wr = !r;
      wt = 4'($urandom_range(10));
      kind = 2'(nacc % 3);
      nacc++;
      if (hit) exp_q.push_back(r ? shadow[a[2:0]] : d);
      if (hit && !r) shadow[a[2:0]] = d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 24);
      chk({31'h0, ack}, {31'h0, hit});
      if (hit) chk(32'(n), 32'(5 + wt));
      else chk(dout, d);
      #1;
      rd = 1'b0;
      wr = 1'b0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (ack === 1'b1 && exp_q.size() == 0) chk(dout ^ 32'h1, dout);
      else if (ack === 1'b1) chk(dout, exp_q.pop_front());
      if (cyc >= 3000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      int i;
      logic [31:0] word;
      void'($urandom(47));
      {nrst, rd, wr, addr, din, wt, kind} = '0;
      ce = 1'b1;
      {err_count, cmp_count, cyc, nacc} = '0;
      repeat (3) @(posedge clk);
      chk({29'h0, ack, sel, rnw}, 32'h0);
      chk(dout | oa | wd, 32'h0);
      chk({27'h0, seq, be}, 32'hF);
      #1 nrst = 1'b1;
      for (i = 0; i < 8; i++) acc(1'b0, BASE + 10'(i), $urandom, 1'b1);
      for (i = 0; i < 8; i++) acc(1'b1, BASE + 10'(7 - i), $urandom, 1'b1);
      acc(1'b1, BASE - 10'h1, $urandom, 1'b0);
      acc(1'b0, BASE + 10'h8, $urandom, 1'b0);
      acc(1'b1, {3'h5, 7'($urandom)}, $urandom, 1'b0);
      acc(1'b1, BASE, $urandom, 1'b1);
      // enable low must freeze the bypass pipeline
      @(posedge clk);
      #1;
      din = $urandom;
      repeat (3) @(posedge clk);
      #1;
      ce = 1'b0;
      word = din;
      din = ~din;
      repeat (3) @(posedge clk);
      chk(dout, word);
      #1 ce = 1'b1;
      repeat (3) @(posedge clk);
      chk(dout, ~word);
      // reset in mid-transfer must drop select at once
      @(posedge clk);
      #1;
      addr = BASE + 10'h2;
      rd = 1'b1;
      wt = 4'hA;
      repeat (3) @(posedge clk);
      #1 nrst = 1'b0;
      rd = 1'b0;
      #1 chk({30'h0, sel, ack}, 32'h0);
      @(posedge clk);
      #1 nrst = 1'b1;
      acc(1'b1, BASE + 10'h2, $urandom, 1'b1);
      repeat (4) @(posedge clk);
      close_out();
   end
endmodule

// ---- logic/dob_bridge.sv ----
`timescale 1ns/100ps
module dob_bridge
   import dob_pkg::*;
#(
   parameter logic [9:0] WINDOW_BASE = DOB_BASE_DEF,
   parameter logic [9:0] WINDOW_MASK = DOB_MASK_DEF,
   parameter logic [31:0] ADDR_OFFSET = DOB_OFFSET_DEF
) (
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_ce,
   // dcr slave side
   input wire logic [9:0] i_dcr_addr,
   input wire logic i_dcr_rd,
   input wire logic i_dcr_wr,
   input wire logic [31:0] i_dcr_data,
   output logic o_dcr_ack,
   output logic [31:0] o_dcr_data,
   // opb master side
   output logic [31:0] o_opb_addr,
   output logic [3:0] o_opb_be,
   output logic [31:0] o_opb_wdata,
   output logic o_opb_rnw,
   output logic o_opb_select,
   output logic o_opb_seq,
   input wire logic [31:0] i_opb_rdata,
   input wire logic i_opb_err_ack,
   input wire logic i_opb_retry,
   input wire logic i_opb_xfer_ack
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   dob_state_e state_q;
   dob_state_e state_d;
   logic [9:0] addr_q;
   logic rd_q;
   logic wr_q;
   logic strobe_prev_q;
   logic [31:0] din_q;
   logic [31:0] rdata_q;
   logic is_read_q;
   logic [31:0] opb_addr_q;
   logic [31:0] opb_wdata_q;
   logic opb_rnw_q;
   logic opb_select_q;
   logic dcr_ack_q;
   logic [31:0] dcr_data_q;
   logic hit;
   logic [31:0] xlat_addr;
   logic strobe_rise;
   logic slave_done;
   logic launch;

   // ----------------------------------------------------------------
   // window decoder
   // ----------------------------------------------------------------
   dob_win_decode #(
      .WINDOW_BASE(WINDOW_BASE),
      .WINDOW_MASK(WINDOW_MASK),
      .ADDR_OFFSET(ADDR_OFFSET)
   ) u_decode (
      .i_dcr_addr(addr_q),
      .o_hit(hit),
      .o_opb_addr(xlat_addr)
   );

   // ----------------------------------------------------------------
   // dcr input pipeline
   // ----------------------------------------------------------------
   // inputs are flopped first; costs a cycle but keeps chain timing short
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         addr_q <= DOB_ADDR_RST;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         strobe_prev_q <= 1'b0;
         din_q <= DOB_WORD_RST;
      end else if (i_ce) begin
         addr_q <= i_dcr_addr;
         rd_q <= i_dcr_rd;
         wr_q <= i_dcr_wr;
         strobe_prev_q <= rd_q | wr_q;
         din_q <= i_dcr_data;
      end
   end

   // ----------------------------------------------------------------
   // control
   // ----------------------------------------------------------------
   assign strobe_rise = (rd_q | wr_q) & ~strobe_prev_q;
   // retry and error count as done; dcr has no way to report them
   assign slave_done = i_opb_xfer_ack | i_opb_retry | i_opb_err_ack;
   // a miss never launches, so the chain sees only the bypass
   assign launch = strobe_rise & hit;

   always_comb begin
      state_d = state_q;
      case (state_q)
         DOB_IDLE: begin
            if (launch) begin
               state_d = DOB_XFER;
            end
         end
         DOB_XFER: begin
            // no timeout here: slave latency must fit the reply budget
            if (slave_done) begin
               state_d = DOB_DONE;
            end
         end
         DOB_DONE: begin
            state_d = DOB_IDLE;
         end
         default: begin
            state_d = DOB_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= DOB_IDLE;
      end else if (i_ce) begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // opb master outputs
   // ----------------------------------------------------------------
   // sole master: select driven straight, no request or grant
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         opb_select_q <= 1'b0;
         opb_addr_q <= DOB_WORD_RST;
         opb_wdata_q <= DOB_WORD_RST;
         opb_rnw_q <= 1'b0;
         is_read_q <= 1'b0;
      end else if (i_ce) begin
         if (state_q == DOB_IDLE && launch) begin
            opb_select_q <= 1'b1;
            opb_addr_q <= xlat_addr;
            opb_wdata_q <= din_q;
            opb_rnw_q <= rd_q;
            is_read_q <= rd_q;
         end else if (state_q == DOB_XFER && slave_done) begin
            opb_select_q <= 1'b0;
            opb_rnw_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // read data capture and dcr answer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_q <= DOB_WORD_RST;
      end else if (i_ce) begin
         if (state_q == DOB_XFER && slave_done) begin
            rdata_q <= i_opb_rdata;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         dcr_ack_q <= 1'b0;
      end else if (i_ce) begin
         dcr_ack_q <= (state_q == DOB_DONE);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         dcr_data_q <= DOB_WORD_RST;
      end else if (i_ce) begin
         if (state_q == DOB_DONE && is_read_q) begin
            dcr_data_q <= rdata_q;
         end else begin
            dcr_data_q <= din_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // port drive
   // ----------------------------------------------------------------
   assign o_dcr_ack = dcr_ack_q;
   assign o_dcr_data = dcr_data_q;
   assign o_opb_addr = opb_addr_q;
   assign o_opb_wdata = opb_wdata_q;
   assign o_opb_rnw = opb_rnw_q;
   assign o_opb_select = opb_select_q;
   // whole words only, single beats only
   assign o_opb_be = DOB_BE_ALL;
   assign o_opb_seq = DOB_SEQ_OFF;

endmodule

// ---- logic/dob_win_decode.sv ----
`timescale 1ns/100ps
module dob_win_decode
   import dob_pkg::*;
#(
   parameter logic [9:0] WINDOW_BASE = DOB_BASE_DEF,
   parameter logic [9:0] WINDOW_MASK = DOB_MASK_DEF,
   parameter logic [31:0] ADDR_OFFSET = DOB_OFFSET_DEF
) (
   input wire logic [9:0] i_dcr_addr,
   output logic o_hit,
   output logic [31:0] o_opb_addr
);

   // ----------------------------------------------------------------
   // build-time checks
   // ----------------------------------------------------------------
   localparam logic [9:0] SPAN_M1 = ~WINDOW_MASK;
   localparam logic [9:0] SPAN_LO = SPAN_M1 + 10'h001;
   // mask must be leading ones so the window is a power of two
   if ((SPAN_M1 & SPAN_LO) != 10'h000) begin : g_bad_mask
      $error("window mask is not a power-of-two size");
   end
   // base must sit on a boundary of the window size
   if ((WINDOW_BASE & SPAN_M1) != 10'h000) begin : g_bad_base
      $error("window base not aligned to window size");
   end

   // ----------------------------------------------------------------
   // decode and translate
   // ----------------------------------------------------------------
   logic [31:0] word_byte;

   assign o_hit = dob_hit(i_dcr_addr, WINDOW_BASE, WINDOW_MASK);
   assign word_byte = {{(DOB_OPB_AW-DOB_DCR_AW-DOB_BYTE_SHIFT){1'b0}},
                       i_dcr_addr, {DOB_BYTE_SHIFT{1'b0}}};
   // wraps modulo 2^32, so a negative offset works as two's complement
   assign o_opb_addr = word_byte + ADDR_OFFSET;

endmodule

// ---- pkg/dob_pkg.sv ----
package dob_pkg;

   // ----------------------------------------------------------------
   // widths and build-time defaults
   // ----------------------------------------------------------------
   localparam int DOB_DCR_AW = 10;
   localparam int DOB_DW = 32;
   localparam int DOB_OPB_AW = 32;
   localparam int DOB_BE_W = 4;
   localparam int DOB_BYTE_SHIFT = 2;
   localparam logic [9:0] DOB_BASE_DEF = 10'h000;
   localparam logic [9:0] DOB_MASK_DEF = 10'h3F8;
   localparam logic [31:0] DOB_OFFSET_DEF = 32'h0000_0000;
   localparam int DOB_REPLY_BUDGET = 16;

   // ----------------------------------------------------------------
   // tied-off opb qualifiers and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] DOB_BE_ALL = 4'hF;
   localparam logic DOB_SEQ_OFF = 1'b0;
   localparam logic [31:0] DOB_WORD_RST = 32'h0000_0000;
   localparam logic [9:0] DOB_ADDR_RST = 10'h000;

   // ----------------------------------------------------------------
   // control states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DOB_IDLE = 2'b00,
      DOB_XFER = 2'b01,
      DOB_DONE = 2'b10
   } dob_state_e;

   // hit test, called only by the window decoder
   function automatic logic dob_hit(input logic [9:0] addr,
                                    input logic [9:0] base,
                                    input logic [9:0] mask);
      dob_hit = ((addr ^ base) & mask) == 10'h000;
   endfunction

endpackage
